// *** common/scs_pkg.sv ***
// shared constants, state codes and step decoding for the six-step
// commutation sequencer; assumes a single 20 MHz system clock.
package scs_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // comparator blanking after a commutation, rounded up to whole cycles
    localparam int BLANK_NS = 4000;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;

    // slowest sector still trusted for back-emf tracking, rounded down
    localparam int LOW_SPEED_US = 2000;
    localparam int LOW_SPEED_CYC = LOW_SPEED_US * CLK_MHZ;

    // electrical geometry: crossing sits mid-sector, i.e. half a sector
    localparam int DEG_SECTOR = 60;
    localparam int DEG_REV = 360;
    localparam int DEG_ZC = 30;
    localparam int ZC_SHIFT = $clog2(DEG_SECTOR / DEG_ZC);
    localparam int WIN_SHIFT = ZC_SHIFT + 1;

    localparam logic [2:0] STEP_FIRST = 3'h1;
    localparam logic [2:0] STEP_LAST = 3'(DEG_REV / DEG_SECTOR);

    // in-window crossings needed before closing the loop
    localparam logic [3:0] GOOD_NEEDED = 4'h6;

    localparam int KP_SHIFT = 4;
    localparam int KI_SHIFT = 6;

    localparam logic [1:0] MODE_OPEN = 2'h0;
    localparam logic [1:0] MODE_CLOSED = 2'h1;
    localparam logic [1:0] MODE_PI = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_OPEN = 2'h1,
        ST_CLOSED = 2'h3
    } scs_state_t;

    // bit 0 is the first winding, bit 2 the third
    function automatic logic [2:0] hi_mask(input logic [2:0] step);
        unique case (step)
            3'h1, 3'h2: hi_mask = 3'h1;
            3'h3, 3'h4: hi_mask = 3'h2;
            3'h5, 3'h6: hi_mask = 3'h4;
            default: hi_mask = 3'h0;
        endcase
    endfunction : hi_mask

    function automatic logic [2:0] lo_mask(input logic [2:0] step);
        unique case (step)
            3'h1, 3'h6: lo_mask = 3'h2;
            3'h2, 3'h3: lo_mask = 3'h4;
            3'h4, 3'h5: lo_mask = 3'h1;
            default: lo_mask = 3'h0;
        endcase
    endfunction : lo_mask

    function automatic logic [2:0] next_step(input logic [2:0] step);
        if (step >= STEP_LAST) begin
            next_step = STEP_FIRST;
        end else begin
            next_step = step + 3'h1;
        end
    endfunction : next_step

endpackage : scs_pkg

// *** verilog/scs_sync.sv ***
// three-stage synchroniser for the phase comparator pins
// assumes the comparators are asynchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
    parameter int W = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } scs_sync_regs_t;

    scs_sync_regs_t q;
    scs_sync_regs_t d;

    // s1 feeds only s2; a bit changes once s2 and s3 agree
    always_comb begin
        d = q;
        d.s1 = i_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_level = q.lvl;

endmodule : scs_sync
`default_nettype wire

// *** verilog/scs_pwm.sv ***
// free-running edge-aligned pwm for the high-side switches
// assumes the duty word is stable or changes between periods harmlessly.
`timescale 1ns/1ps
`default_nettype none
module scs_pwm #(
    parameter int W = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_duty,
    output logic o_pwm
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic pwm;
    } scs_pwm_regs_t;

    scs_pwm_regs_t q;
    scs_pwm_regs_t d;

    always_comb begin
        d.cnt = q.cnt + 1'b1;
        d.pwm = q.cnt < i_duty;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_pwm = q.pwm;

endmodule : scs_pwm
`default_nettype wire

// *** verilog/scs_sequencer.sv ***
// six-step sensorless commutation sequencer with zero-crossing timing
// assumes i_cmp[n] is an external comparator, high while winding n sits
// above half the dc_bus_voltage, and a bridge driven by the gate outputs.
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
    parameter int CNT_W = 18,
    parameter int DUTY_W = 8,
    parameter int LOW_SPEED_CYC = scs_pkg::LOW_SPEED_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [1:0] i_mode,
    input wire logic [DUTY_W-1:0] i_duty,
    input wire logic [CNT_W-1:0] i_ol_period,
    input wire logic [CNT_W-1:0] i_period_ref,
    input wire logic [2:0] i_cmp,
    output logic [2:0] o_gate_hi,
    output logic [2:0] o_gate_lo,
    output logic [2:0] o_float,
    output logic [2:0] o_step,
    output logic o_zc,
    output logic o_commutate,
    output logic o_closed,
    output logic [CNT_W-1:0] o_period,
    output logic [DUTY_W-1:0] o_duty
);

    localparam int ACC_W = CNT_W + 2;
    localparam logic [CNT_W-1:0] BLANK = CNT_W'(scs_pkg::BLANK_CYC);
    localparam logic [CNT_W-1:0] LOW = CNT_W'(LOW_SPEED_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic signed [ACC_W-1:0] DMAX = ACC_W'((1 << DUTY_W) - 1);

    typedef struct packed {
        scs_pkg::scs_state_t st;
        logic [2:0] step;
        logic [CNT_W-1:0] sect_cnt;
        logic [CNT_W-1:0] since_zc;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] dly;
        logic dly_run;
        logic zc_seen;
        logic prev_lvl;
        logic [3:0] good;
        logic [DUTY_W-1:0] integ;
        logic [DUTY_W-1:0] duty;
        logic [2:0] gate_hi;
        logic [2:0] gate_lo;
        logic [2:0] flt;
        logic zc_p;
        logic com_p;
    } scs_regs_t;

    localparam scs_regs_t REG_RST = '{
        st: scs_pkg::ST_IDLE,
        step: scs_pkg::STEP_FIRST,
        default: '0
    };

    scs_regs_t q;
    scs_regs_t d;

    logic [2:0] cmp_s;
    logic pwm;

    scs_sync #(
        .W(3)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(i_cmp),
        .o_level(cmp_s)
    );

    scs_pwm #(
        .W(DUTY_W)
    ) u_pwm (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_duty(q.duty),
        .o_pwm(pwm)
    );

    function automatic logic [DUTY_W-1:0] duty_clamp(
        input logic signed [ACC_W-1:0] v
    );
        if (v < 0) begin
            duty_clamp = '0;
        end else if (v > DMAX) begin
            duty_clamp = '1;
        end else begin
            duty_clamp = v[DUTY_W-1:0];
        end
    endfunction : duty_clamp

    logic [2:0] hi;
    logic [2:0] lo;
    logic [2:0] flt;
    logic running;
    logic lvl;
    logic post;
    logic zc;
    logic in_win;
    logic fast;
    logic com;
    logic [CNT_W-1:0] ref_p;
    logic signed [ACC_W-1:0] err;
    logic signed [ACC_W-1:0] ie;
    logic [DUTY_W-1:0] ni;

    always_comb begin
        d = q;
        d.zc_p = 1'b0;
        d.com_p = 1'b0;
        com = 1'b0;
        running = q.st != scs_pkg::ST_IDLE;
        hi = scs_pkg::hi_mask(q.step);
        lo = scs_pkg::lo_mask(q.step);
        flt = ~(hi | lo);
        // only the undriven winding is looked at
        lvl = |(flt & cmp_s);
        // odd steps fall through mid-bus, even steps rise
        post = ~q.step[0];
        zc = running && (q.sect_cnt >= BLANK) && !q.zc_seen
            && (lvl == post) && (q.prev_lvl != post);
        d.prev_lvl = lvl;
        // crossing must land mid-sector, a quarter sector either way
        ref_p = (q.st == scs_pkg::ST_OPEN) ? i_ol_period : q.period;
        in_win = (q.sect_cnt >= (ref_p >> scs_pkg::WIN_SHIFT))
            && (q.sect_cnt <= ref_p - (ref_p >> scs_pkg::WIN_SHIFT));
        fast = q.since_zc < LOW;
        err = $signed({2'b00, q.since_zc})
            - $signed({2'b00, i_period_ref});
        ie = $signed({{(ACC_W - DUTY_W){1'b0}}, q.integ});
        ni = duty_clamp(ie + (err >>> scs_pkg::KI_SHIFT));

        if (q.sect_cnt != CNT_MAX) begin
            d.sect_cnt = q.sect_cnt + 1'b1;
        end
        if (q.since_zc != CNT_MAX) begin
            d.since_zc = q.since_zc + 1'b1;
        end

        unique case (q.st)
            scs_pkg::ST_IDLE: begin
                if (i_enable) begin
                    // always start from step one without feedback
                    d.st = scs_pkg::ST_OPEN;
                    d.step = scs_pkg::STEP_FIRST;
                    d.sect_cnt = '0;
                    d.since_zc = '0;
                    d.good = '0;
                    d.zc_seen = 1'b0;
                end
            end
            scs_pkg::ST_OPEN: begin
                // forced sector rate sets the speed here
                com = q.sect_cnt >= i_ol_period;
                if (zc) begin
                    if (in_win && fast) begin
                        if (q.good != scs_pkg::GOOD_NEEDED) begin
                            d.good = q.good + 1'b1;
                        end
                        if (q.good + 1'b1 >= scs_pkg::GOOD_NEEDED
                            && i_mode != scs_pkg::MODE_OPEN) begin
                            d.st = scs_pkg::ST_CLOSED;
                        end
                    end else begin
                        d.good = '0;
                    end
                end
            end
            scs_pkg::ST_CLOSED: begin
                com = q.dly_run && (q.dly == '0);
                // a lost or slow crossing hands back to forced stepping
                if (q.period >= LOW || i_mode == scs_pkg::MODE_OPEN
                    || q.sect_cnt >= {q.period[CNT_W-2:0], 1'b0}) begin
                    d.st = scs_pkg::ST_OPEN;
                    d.good = '0;
                    d.dly_run = 1'b0;
                end
            end
            default: begin
                d.st = scs_pkg::ST_IDLE;
            end
        endcase

        if (zc) begin
            d.zc_seen = 1'b1;
            d.zc_p = 1'b1;
            // take the incremented count so both end cycles are counted
            d.period = d.since_zc;
            d.dly = d.since_zc >> scs_pkg::ZC_SHIFT;
            d.since_zc = '0;
            d.dly_run = d.st == scs_pkg::ST_CLOSED;
        end else if (q.dly_run && q.dly != '0) begin
            d.dly = q.dly - 1'b1;
        end

        // step advances only here, at the sector boundary
        if (com) begin
            d.step = scs_pkg::next_step(q.step);
            d.sect_cnt = '0;
            d.zc_seen = 1'b0;
            d.dly_run = 1'b0;
            d.com_p = 1'b1;
        end

        // pi loop trims duty once per crossing; other modes track the
        // input and preload the integrator so a switch is bumpless
        if (i_mode == scs_pkg::MODE_PI && q.st == scs_pkg::ST_CLOSED) begin
            if (zc) begin
                d.integ = ni;
                d.duty = duty_clamp(
                    $signed({{(ACC_W - DUTY_W){1'b0}}, ni})
                    + (err >>> scs_pkg::KP_SHIFT));
            end
        end else begin
            d.integ = i_duty;
            d.duty = i_duty;
        end

        if (!i_enable) begin
            d.st = scs_pkg::ST_IDLE;
            d.step = scs_pkg::STEP_FIRST;
            d.dly_run = 1'b0;
        end

        // gates follow the next step so they line up with o_step
        if (d.st != scs_pkg::ST_IDLE) begin
            d.gate_hi = scs_pkg::hi_mask(d.step) & {3{pwm}};
            d.gate_lo = scs_pkg::lo_mask(d.step);
            d.flt = ~(scs_pkg::hi_mask(d.step)
                | scs_pkg::lo_mask(d.step));
        end else begin
            d.gate_hi = 3'h0;
            d.gate_lo = 3'h0;
            d.flt = 3'h0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            q <= REG_RST;
        end else begin
            q <= d;
        end
    end

    assign o_gate_hi = q.gate_hi;
    assign o_gate_lo = q.gate_lo;
    assign o_float = q.flt;
    assign o_step = q.step;
    assign o_zc = q.zc_p;
    assign o_commutate = q.com_p;
    assign o_closed = q.st[1];  // only the closed code has bit 1 set
    assign o_period = q.period;
    assign o_duty = q.duty;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    logic q_run;
    assign q_run = q.st != scs_pkg::ST_IDLE;

    step_one_a: assert property (
        q_run && q.step == 3'h1
        |-> q.gate_lo == 3'h2 && (q.gate_hi & 3'h6) == 3'h0
            && q.flt == 3'h4)
        else $error("step one drive pattern wrong");
    step_two_a: assert property (
        q_run && q.step == 3'h2
        |-> q.gate_lo == 3'h4 && (q.gate_hi & 3'h6) == 3'h0
            && q.flt == 3'h2)
        else $error("step two drive pattern wrong");
    steps_mid_a: assert property (
        q_run && (q.step == 3'h3 || q.step == 3'h4)
        |-> (q.gate_hi & 3'h5) == 3'h0
            && q.gate_lo == ((q.step == 3'h3) ? 3'h4 : 3'h1))
        else $error("step three or four drive wrong");
    steps_late_a: assert property (
        q_run && (q.step == 3'h5 || q.step == 3'h6)
        |-> (q.gate_hi & 3'h3) == 3'h0
            && q.gate_lo == ((q.step == 3'h5) ? 3'h1 : 3'h2))
        else $error("step five or six drive wrong");
    one_floating_a: assert property (
        q_run |-> $onehot(q.gate_lo) && $onehot(q.flt)
            && (q.gate_hi & (q.gate_lo | q.flt)) == 3'h0)
        else $error("not exactly one floating winding");
    step_order_a: assert property (
        q_run && q.com_p
        |-> q.step == scs_pkg::next_step($past(q.step))
            && q.step >= scs_pkg::STEP_FIRST
            && q.step <= scs_pkg::STEP_LAST)
        else $error("step did not advance in order");
    open_rate_a: assert property (
        q.st == scs_pkg::ST_OPEN && $past(q.st) == scs_pkg::ST_OPEN
        && q.com_p |-> $past(q.sect_cnt) >= $past(i_ol_period))
        else $error("open-loop commutation too early");
    zc_delay_a: assert property (
        q.zc_p && q.dly_run
        |-> q.dly == (q.period >> scs_pkg::ZC_SHIFT))
        else $error("commutation delay not half interval");
    closed_com_a: assert property (
        q.st == scs_pkg::ST_CLOSED && $past(q.st) == scs_pkg::ST_CLOSED
        && q.com_p |-> $past(q.zc_seen) && $past(q.dly) == '0)
        else $error("closed-loop commutation without crossing");
    period_meas_a: assert property (
        q.zc_p |-> q.since_zc == '0 && (q.period == $past(q.since_zc) + 1'b1
            || $past(q.since_zc) == CNT_MAX))
        else $error("crossing interval not captured");
    pwm_gate_a: assert property (
        q.gate_hi != 3'h0 |-> $past(pwm))
        else $error("high side on while pwm low");
    low_speed_a: assert property (
        q.st == scs_pkg::ST_CLOSED && q.period >= LOW
        |=> q.st != scs_pkg::ST_CLOSED)
        else $error("closed loop kept at low speed");
    mode_gate_a: assert property (
        q.st == scs_pkg::ST_CLOSED && $past(q.st) == scs_pkg::ST_CLOSED
        |-> $past(i_mode) != scs_pkg::MODE_OPEN)
        else $error("loop closed in open-loop mode");
    start_step_a: assert property (
        q.st == scs_pkg::ST_OPEN && $past(q.st) == scs_pkg::ST_IDLE
        |-> q.step == scs_pkg::STEP_FIRST)
        else $error("run did not start at step one");

    disable_off_a: assert property (
        !i_enable |=> q.gate_hi == 3'h0 && q.gate_lo == 3'h0)
        else $error("winding driven while disabled");

    closed_com_c: cover property (
        q.st == scs_pkg::ST_CLOSED && q.com_p);
    step_wrap_c: cover property (
        q.com_p && q.step == scs_pkg::STEP_FIRST && q_run);
    pi_trim_c: cover property (
        i_mode == scs_pkg::MODE_PI && q.zc_p && $changed(q.duty));
    fall_back_c: cover property (
        $past(q.st) == scs_pkg::ST_CLOSED && q.st == scs_pkg::ST_OPEN);

endmodule : scs_sequencer
`default_nettype wire

// *** sim/scs_motor_model.sv ***
// stand-in for the bridge and motor: drives the three comparator pins
// assumes steps 1..6 and a crossing i_zc_dly cycles into each sector
`timescale 1ns/1ps
`default_nettype none
module scs_motor_model (
    input wire logic i_sys_clk,
    input wire logic i_spin,
    input wire logic [15:0] i_zc_dly,
    input wire logic [2:0] i_step,
    input wire logic [2:0] i_float,
    input wire logic [2:0] i_gate_lo,
    output logic [2:0] o_cmp
);
    logic [2:0] last_step = 3'h0;
    logic [15:0] cnt = 16'h0;
    logic post;

    // sector age restarts whenever the step moves on
    always @(posedge i_sys_clk) begin
        if (i_step != last_step) begin
            cnt <= 16'h0;
        end else if (cnt != 16'hffff) begin
            cnt <= cnt + 16'h1;
        end
        last_step <= i_step;
    end

    // a stopped rotor makes no usable back-emf, so no edge at all
    assign post = i_spin && (cnt >= i_zc_dly);

    // floating winding falls through mid-bus in odd steps, rises in even
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            if (i_float[k] === 1'b1) begin
                o_cmp[k] = i_step[0] ^ post;
            end else begin
                o_cmp[k] = (i_gate_lo[k] !== 1'b1);
            end
        end
    end
endmodule : scs_motor_model
`default_nettype wire

// *** sim/scs_sequencer_tb.sv ***
// self-checking bench for the commutation sequencer
// assumes the motor model stands on the comparator pins
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_tb;
    localparam int LOW_CYC = 2000;
    logic i_sys_clk, i_rst, i_enable, spin;
    logic [1:0] i_mode;
    logic [7:0] i_duty, o_duty;
    logic [17:0] i_ol_period, i_period_ref, o_period;
    logic [2:0] i_cmp, o_gate_hi, o_gate_lo, o_float, o_step;
    logic o_zc, o_commutate, o_closed;
    logic [15:0] zc_dly;
    logic [2:0] hi_t [1:6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    logic [2:0] lo_t [1:6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    logic [2:0] fl_t [1:6] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h2, 3'h1};
    int fails, samples_checked, hi_bad, hi_on;

    scs_sequencer #(.LOW_SPEED_CYC(LOW_CYC)) u_scs_sequencer (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_enable(i_enable),
        .i_mode(i_mode), .i_duty(i_duty), .i_ol_period(i_ol_period),
        .i_period_ref(i_period_ref), .i_cmp(i_cmp),
        .o_gate_hi(o_gate_hi), .o_gate_lo(o_gate_lo), .o_float(o_float),
        .o_step(o_step), .o_zc(o_zc), .o_commutate(o_commutate),
        .o_closed(o_closed), .o_period(o_period), .o_duty(o_duty)
    );

    scs_motor_model u_scs_motor_model (
        .i_sys_clk(i_sys_clk), .i_spin(spin), .i_zc_dly(zc_dly),
        .i_step(o_step), .i_float(o_float), .i_gate_lo(o_gate_lo),
        .o_cmp(i_cmp)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    task automatic results();
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                       input string m);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    function automatic logic pick(input int w);
        case (w)
            0: pick = o_commutate;
            1: pick = o_zc;
            2: pick = o_closed;
            default: pick = ~o_closed;
        endcase
    endfunction : pick

    // counts cycles until the chosen event; also audits the high side
    task automatic wait_on(input int w, input int lim, output int n);
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
            if ((o_gate_hi & ~hi_t[o_step]) !== 3'h0) hi_bad++;
            if (o_gate_hi !== 3'h0) hi_on++;
        end while (pick(w) !== 1'b1 && n < lim);
        if (pick(w) !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, "wait ran out");
            results();
        end
    endtask : wait_on

    task automatic t_reset();
        @(negedge i_sys_clk);
        chk({o_gate_hi, o_gate_lo, o_float}, 18'h0, "idle gates");
        chk(o_step, 18'h1, "idle step");
        chk({o_closed, o_zc, o_commutate}, 18'h0, "idle flags");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_open();
        int n;
        logic [2:0] s;
        s = 3'h1;
        hi_bad = 0;
        hi_on = 0;
        @(posedge i_sys_clk);
        i_enable <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            wait_on(0, 400, n);
            s = (s == 3'h6) ? 3'h1 : s + 3'h1;
            if (k > 0) chk(n, 18'h64, "sector length");
            chk(o_step, s, "step order");
            chk(o_gate_lo, lo_t[s], "low side");
            chk(o_float, fl_t[s], "floating");
        end
        chk(hi_bad, 18'h0, "high side off step");
        chk(hi_on > 150 && hi_on < 550, 18'h1, "pwm share");
        @(posedge i_sys_clk);
        i_enable <= 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk({o_gate_hi, o_gate_lo, o_float}, 18'h0, "disabled");
        $display("t_open done");
    endtask : t_open

    task automatic t_track();
        int n;
        @(posedge i_sys_clk);
        i_ol_period <= 18'h1f3;
        i_mode <= 2'h1;
        spin <= 1'b1;
        i_enable <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wait_on(1, 1200, n);
        end
        chk(o_period, 18'h1f4, "crossing interval");
        chk(o_closed, 18'h0, "closed too early");
        wait_on(2, 6000, n);
        $display("t_track done");
    endtask : t_track

    task automatic t_closed();
        int n, h, c;
        // c + n is the bench's own crossing-to-crossing count; the first
        // wait starts on the crossing that closed the loop
        c = 0;
        for (int k = 0; k < 4; k++) begin
            wait_on(1, 1500, n);
            h = (c + n) / 2;
            chk(o_period, c + n, "interval");
            if (k > 0) chk(n > h - 12 && n < h + 12, 18'h1, "mid");
            wait_on(0, 1500, c);
            chk(c >= h - 1 && c <= h + 3, 18'h1, "commute");
        end
        chk(o_closed, 18'h1, "loop held");
        $display("t_closed done");
    endtask : t_closed

    task automatic t_pi();
        int n;
        @(posedge i_sys_clk);
        i_mode <= 2'h2;
        for (int k = 0; k < 4; k++) begin
            wait_on(1, 1500, n);
        end
        chk(o_duty > i_duty, 18'h1, "pi duty up");
        @(posedge i_sys_clk);
        i_mode <= 2'h0;
        repeat (3) @(negedge i_sys_clk);
        chk(o_closed, 18'h0, "open on mode 0");
        chk(o_duty, 18'h80, "fixed duty");
        $display("t_pi done");
    endtask : t_pi

    task automatic t_stall();
        int n;
        @(posedge i_sys_clk);
        i_mode <= 2'h1;
        wait_on(2, 8000, n);
        @(posedge i_sys_clk);
        spin <= 1'b0;
        wait_on(3, 1600, n);
        chk(n > 600, 18'h1, "held through stall");
        wait_on(0, 600, n);
        $display("t_stall done");
    endtask : t_stall

    initial begin
        i_rst = 1'b1;
        i_enable = 1'b0;
        i_mode = 2'h0;
        i_duty = 8'h80;
        i_ol_period = 18'h63;
        i_period_ref = 18'h190;
        spin = 1'b0;
        zc_dly = 16'hf0;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_reset();
        t_open();
        t_track();
        t_closed();
        t_pi();
        t_stall();
        results();
    end
endmodule : scs_sequencer_tb
`default_nettype wire
